// file: uts_pkg.sv
package uts_pkg;

    localparam int APB_AW = 16;
    localparam int DATA_BITS = 8;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] IDX_CTRL_ONE = 16'h0025;
    localparam logic [15:0] IDX_STATUS = 16'h0025;
    localparam logic [15:0] IDX_CTRL_TWO = 16'h0026;
    localparam logic [15:0] IDX_DATA = 16'h0f9b;
    localparam logic [15:0] ADDR_CTRL_ONE = 16'(IDX_CTRL_ONE * 4);
    localparam logic [15:0] ADDR_STATUS = 16'(IDX_STATUS * 4);
    localparam logic [15:0] ADDR_CTRL_TWO = 16'(IDX_CTRL_TWO * 4);
    localparam logic [15:0] ADDR_DATA = 16'(IDX_DATA * 4);

    // Field positions
    localparam int RX_STOP_BIT = 0;
    localparam int ST_OVERRUN_ERR_BIT = 5;

    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic tx_stop_len;
        logic parity_even;
        logic parity_add;
        logic [2:0] baud_select;
    } uts_ctrl_s;

    // Status byte is {flags, 2'b00}
    typedef struct packed {
        logic parity_err;
        logic framing_err;
        logic overrun_err;
        logic rx_buf_full;
        logic tx_done;
        logic tx_buf_empty;
    } uts_flags_s;

    localparam uts_ctrl_s CTRL_RESET = 8'h00;
    localparam uts_flags_s FLAGS_RESET = 6'h03;
    localparam logic [7:0] HOLD_RESET = 8'h00;
    localparam logic RX_STOP_RESET = 1'b0;

    // Sub-clock positions within one bit (16 per bit)
    localparam logic [3:0] SUB_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;
    // Start, eight data bits and one stop bit
    localparam logic [3:0] FRAME_BASE = 4'ha;

    // Baud select codes and divisors of the system clock
    localparam logic [2:0] BAUD_DIV13 = 3'h0;
    localparam logic [2:0] BAUD_DIV26 = 3'h1;
    localparam logic [2:0] BAUD_DIV52 = 3'h2;
    localparam logic [2:0] BAUD_DIV104 = 3'h3;
    localparam logic [2:0] BAUD_DIV208 = 3'h4;
    localparam logic [2:0] BAUD_DIV416 = 3'h5;
    localparam logic [2:0] BAUD_TIMER = 3'h6;
    localparam logic [2:0] BAUD_DIV96 = 3'h7;
    localparam logic [8:0] DIV_13 = 9'h00d;
    localparam logic [8:0] DIV_26 = 9'h01a;
    localparam logic [8:0] DIV_52 = 9'h034;
    localparam logic [8:0] DIV_104 = 9'h068;
    localparam logic [8:0] DIV_208 = 9'h0d0;
    localparam logic [8:0] DIV_416 = 9'h1a0;
    localparam logic [8:0] DIV_96 = 9'h060;

    typedef enum logic {TX_IDLE, TX_SHIFT} uts_tx_state_e;
    typedef enum logic {RX_IDLE, RX_FRAME} uts_rx_state_e;

endpackage

// file: uts_baud.sv
`timescale 1ns/1ps
`default_nettype none
module uts_baud import uts_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Rate selection
    input wire logic [2:0] baud_select,
    input wire logic timer_five_out,
    // Sub-clock tick, one cycle wide
    output logic tick
);

    logic [8:0] cnt;
    logic [8:0] next_cnt;
    logic [8:0] limit;
    logic next_tick;

    always_comb begin
        case (baud_select) // [R18]
            BAUD_DIV13: limit = DIV_13;
            BAUD_DIV26: limit = DIV_26;
            BAUD_DIV52: limit = DIV_52;
            BAUD_DIV104: limit = DIV_104;
            BAUD_DIV208: limit = DIV_208;
            BAUD_DIV416: limit = DIV_416;
            BAUD_DIV96: limit = DIV_96;
            default: limit = DIV_13;
        endcase
        next_cnt = cnt;
        next_tick = 1'b0;
        if (baud_select == BAUD_TIMER) begin // [R18]
            next_cnt = 9'h000;
            next_tick = timer_five_out;
        end else if (cnt >= 9'(limit - 9'h001)) begin
            next_cnt = 9'h000;
            next_tick = 1'b1;
        end else begin
            next_cnt = 9'(cnt + 9'h001);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt <= 9'h000;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end

endmodule // uts_baud
`default_nettype wire

// file: uts_uart.sv
// Behaviour
// R1 - Armed data write clears buffer-empty, loads byte and starts shifting it out.
// R2 - Frame is start bit, eight data bits, optional parity, one or two stops.
// R3 - Frame start sets buffer-empty and pulses the transmit event.
// R4 - Transmit line idles high when disabled or before the first byte.
// R5 - Data write without prior status read is ignored; buffer-empty stays set.
// R6 - Software enables, reads status, checks buffer-empty before each write.
// R7 - After stop bits, data goes to receive buffer, full flag, receive event.
// R8 - Clearing receive enable only stops new frames; current frame completes.
// R9 - Parity mismatch on received frame sets the parity error flag.
// R10 - A zero sampled at any stop position sets the framing error flag.
// R11 - Frame arriving while buffer full sets overrun, data dropped, buffer kept.
// R12 - While overrun is set no new frame is accepted.
// R13 - Status read then buffer read clears parity, framing, overrun, full flags.
// R14 - Overrun set after the status read survives the following buffer read.
// R15 - Loading the receive buffer sets the full flag.
// R16 - Done flag sets at frame end with empty buffer, clears at next start.
// R17 - Each bit sampled at sub-clock seven, eight, nine; two of three decide.
// R18 - Baud select picks divisor 13 to 416, 96, or timer five output.
// R19 - Parity add enables parity; type bit picks odd at 0, even at 1.
// R20 - Receive stop length picks one or two stops independent of transmit.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uts_uart import uts_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial lines
    input wire logic ser_in,
    output logic ser_out,
    // Baud source and events
    input wire logic timer_five_out,
    output logic tx_irq,
    output logic rx_irq
);

    function automatic logic par_of(input logic [7:0] d, input logic even);
        par_of = even ? ^d : ~^d; // [R19]
    endfunction

    logic tick;
    logic setup, acc_rd, acc_wr;
    logic hit_one, hit_two, hit_data;
    logic status_rd, data_rd, data_wr;

    uts_ctrl_s ctrl, next_ctrl;
    uts_flags_s flags, next_flags;
    logic rx_stop_len, next_rx_stop_len;
    logic [7:0] tx_holding, next_tx_holding;
    logic [7:0] rx_holding, next_rx_holding;
    logic arm_tx, next_arm_tx, arm_rx, next_arm_rx, oe_seen, next_oe_seen;
    logic [31:0] next_prdata;
    logic next_pslverr;

    uts_tx_state_e tx_state, next_tx_state;
    logic [3:0] tx_sub, next_tx_sub, tx_bit, next_tx_bit, tx_len, next_tx_len;
    logic [10:0] tx_shift, next_tx_shift;
    logic next_ser_out, tx_start, tx_end;

    logic rx_meta, rx_sync;
    uts_rx_state_e rx_state, next_rx_state;
    logic [3:0] rx_sub, next_rx_sub, rx_bit, next_rx_bit, rx_len, next_rx_len;
    logic [1:0] rx_ones, next_rx_ones;
    logic [7:0] rx_data, next_rx_data;
    logic rx_pe_acc, next_rx_pe_acc, rx_fe_acc, next_rx_fe_acc;
    logic rx_finish, rx_load, rx_overrun, bitval, is_stop;

    uts_baud u_baud (
        .clk(clk),
        .rst_b(rst_b),
        .baud_select(ctrl.baud_select),
        .timer_five_out(timer_five_out),
        .tick(tick)
    );

    assign pready = 1'b1;
    assign setup = psel && !penable;
    assign acc_rd = psel && penable && !pwrite;
    assign acc_wr = psel && penable && pwrite;
    assign hit_one = (paddr == ADDR_CTRL_ONE);
    assign hit_two = (paddr == ADDR_CTRL_TWO);
    assign hit_data = (paddr == ADDR_DATA);
    assign status_rd = acc_rd && (paddr == ADDR_STATUS);
    assign data_rd = acc_rd && hit_data;
    assign data_wr = acc_wr && hit_data;

    // Registers, flags and read data
    always_comb begin
        next_ctrl = ctrl;
        next_rx_stop_len = rx_stop_len;
        next_flags = flags;
        next_tx_holding = tx_holding;
        next_rx_holding = rx_holding;
        next_arm_tx = arm_tx;
        next_arm_rx = arm_rx;
        next_oe_seen = oe_seen;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup) begin
            next_pslverr = !(hit_one || hit_two || hit_data);
            if (!pwrite && hit_one) begin
                next_prdata = {24'h00_0000, flags, 2'b00};
            end else if (!pwrite && hit_data) begin
                next_prdata = {24'h00_0000, rx_holding};
            end else begin
                next_prdata = 32'h0000_0000;
            end
        end
        if (acc_wr && hit_one) begin
            next_ctrl = uts_ctrl_s'(pwdata[7:0]);
        end
        if (acc_wr && hit_two) begin
            next_rx_stop_len = pwdata[RX_STOP_BIT];
        end
        if (status_rd) begin // [R6]
            next_arm_tx = 1'b1;
            next_arm_rx = 1'b1;
            next_oe_seen = prdata[ST_OVERRUN_ERR_BIT];
        end
        if (data_wr) begin
            next_arm_tx = 1'b0;
            if (arm_tx) begin // [R1] [R5]
                next_tx_holding = pwdata[7:0];
                next_flags.tx_buf_empty = 1'b0;
            end
        end
        if (data_rd && arm_rx) begin // [R13]
            next_arm_rx = 1'b0;
            next_flags.parity_err = 1'b0;
            next_flags.framing_err = 1'b0;
            next_flags.rx_buf_full = 1'b0;
            if (oe_seen) begin // [R14]
                next_flags.overrun_err = 1'b0;
            end
        end
        // Hardware sets come last so they win over a clear in the same cycle
        if (tx_start) begin // [R3]
            next_flags.tx_buf_empty = 1'b1;
            next_flags.tx_done = 1'b0; // [R16]
        end
        if (tx_end && flags.tx_buf_empty) begin // [R16]
            next_flags.tx_done = 1'b1;
        end
        if (rx_load) begin // [R7]
            next_rx_holding = rx_data;
            next_flags.rx_buf_full = 1'b1; // [R15]
            next_flags.parity_err = next_flags.parity_err | rx_pe_acc; // [R9]
            next_flags.framing_err = next_flags.framing_err | rx_fe_acc
                                     | (is_stop && !bitval); // [R10]
        end
        if (rx_overrun) begin // [R11]
            next_flags.overrun_err = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl <= CTRL_RESET;
            rx_stop_len <= RX_STOP_RESET;
            flags <= FLAGS_RESET;
            tx_holding <= HOLD_RESET;
            rx_holding <= HOLD_RESET;
            arm_tx <= 1'b0;
            arm_rx <= 1'b0;
            oe_seen <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            rx_stop_len <= next_rx_stop_len;
            flags <= next_flags;
            tx_holding <= next_tx_holding;
            rx_holding <= next_rx_holding;
            arm_tx <= next_arm_tx;
            arm_rx <= next_arm_rx;
            oe_seen <= next_oe_seen;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Transmitter; a disable lets the current frame finish
    assign tx_start = (tx_state == TX_IDLE) && ctrl.tx_enable && !flags.tx_buf_empty; // [R1]
    assign tx_end = (tx_state == TX_SHIFT) && tick && (tx_sub == SUB_LAST)
                    && (tx_bit == 4'(tx_len - 4'h1));

    always_comb begin
        next_tx_state = tx_state;
        next_tx_sub = tx_sub;
        next_tx_bit = tx_bit;
        next_tx_len = tx_len;
        next_tx_shift = tx_shift;
        case (tx_state)
            TX_IDLE: begin
                if (tx_start) begin // [R2]
                    next_tx_state = TX_SHIFT;
                    next_tx_sub = 4'h0;
                    next_tx_bit = 4'h0;
                    next_tx_len = 4'(FRAME_BASE + {3'b000, ctrl.parity_add}
                                     + {3'b000, ctrl.tx_stop_len});
                    next_tx_shift = {1'b1,
                                     ctrl.parity_add ? par_of(tx_holding, ctrl.parity_even) : 1'b1,
                                     tx_holding, 1'b0}; // [R19]
                end
            end
            TX_SHIFT: begin
                if (tick) begin
                    next_tx_sub = 4'(tx_sub + 4'h1);
                    if (tx_sub == SUB_LAST) begin
                        if (tx_end) begin
                            next_tx_state = TX_IDLE;
                        end else begin
                            next_tx_bit = 4'(tx_bit + 4'h1);
                            next_tx_shift = {1'b1, tx_shift[10:1]};
                        end
                    end
                end
            end
            default: next_tx_state = TX_IDLE;
        endcase
        next_ser_out = (next_tx_state == TX_SHIFT) ? next_tx_shift[0] : 1'b1; // [R4]
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_state <= TX_IDLE;
            tx_sub <= 4'h0;
            tx_bit <= 4'h0;
            tx_len <= FRAME_BASE;
            tx_shift <= 11'h7ff;
            ser_out <= 1'b1;
            tx_irq <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_sub <= next_tx_sub;
            tx_bit <= next_tx_bit;
            tx_len <= next_tx_len;
            tx_shift <= next_tx_shift;
            ser_out <= next_ser_out;
            tx_irq <= tx_start; // [R3]
        end
    end

    // Receiver
    assign bitval = rx_ones[1]; // [R17]
    assign is_stop = (rx_bit > 4'(DATA_BITS + int'(ctrl.parity_add))); // [R20]
    assign rx_finish = (rx_state == RX_FRAME) && tick && (rx_sub == SUB_LAST)
                       && (rx_bit == 4'(rx_len - 4'h1));
    assign rx_load = rx_finish && !flags.rx_buf_full;
    assign rx_overrun = rx_finish && flags.rx_buf_full; // [R11]

    always_comb begin
        next_rx_state = rx_state;
        next_rx_sub = rx_sub;
        next_rx_bit = rx_bit;
        next_rx_len = rx_len;
        next_rx_ones = rx_ones;
        next_rx_data = rx_data;
        next_rx_pe_acc = rx_pe_acc;
        next_rx_fe_acc = rx_fe_acc;
        case (rx_state)
            RX_IDLE: begin
                if (tick && ctrl.rx_enable && !flags.overrun_err && !rx_sync) begin // [R8] [R12]
                    next_rx_state = RX_FRAME;
                    next_rx_sub = 4'h1;
                    next_rx_bit = 4'h0;
                    next_rx_ones = 2'b00;
                    next_rx_pe_acc = 1'b0;
                    next_rx_fe_acc = 1'b0;
                    next_rx_len = 4'(FRAME_BASE + {3'b000, ctrl.parity_add}
                                     + {3'b000, rx_stop_len}); // [R20]
                end
            end
            RX_FRAME: begin
                if (tick) begin
                    next_rx_sub = 4'(rx_sub + 4'h1);
                    if (rx_sub == SAMPLE_A || rx_sub == SAMPLE_B || rx_sub == SAMPLE_C) begin
                        next_rx_ones = 2'(rx_ones + {1'b0, rx_sync}); // [R17]
                    end
                    if (rx_sub == SUB_LAST) begin
                        next_rx_ones = 2'b00;
                        next_rx_bit = 4'(rx_bit + 4'h1);
                        if (rx_bit == 4'h0 && bitval) begin
                            next_rx_state = RX_IDLE;
                        end else if (rx_bit != 4'h0 && rx_bit <= 4'(DATA_BITS)) begin
                            next_rx_data = {bitval, rx_data[7:1]};
                        end else if (rx_bit != 4'h0 && !is_stop) begin
                            next_rx_pe_acc = bitval != par_of(rx_data, ctrl.parity_even); // [R9]
                        end else if (is_stop && !bitval) begin
                            next_rx_fe_acc = 1'b1; // [R10]
                        end
                        if (rx_finish) begin
                            next_rx_state = RX_IDLE;
                        end
                    end
                end
            end
            default: next_rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_state <= RX_IDLE;
            rx_sub <= 4'h0;
            rx_bit <= 4'h0;
            rx_len <= FRAME_BASE;
            rx_ones <= 2'b00;
            rx_data <= HOLD_RESET;
            rx_pe_acc <= 1'b0;
            rx_fe_acc <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            rx_meta <= ser_in;
            rx_sync <= rx_meta;
            rx_state <= next_rx_state;
            rx_sub <= next_rx_sub;
            rx_bit <= next_rx_bit;
            rx_len <= next_rx_len;
            rx_ones <= next_rx_ones;
            rx_data <= next_rx_data;
            rx_pe_acc <= next_rx_pe_acc;
            rx_fe_acc <= next_rx_fe_acc;
            rx_irq <= rx_load; // [R7]
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_tx_armed_write: assert property (data_wr && arm_tx |=> !flags.tx_buf_empty) // [R1]
        else $error("armed write did not clear buffer empty");
    a_tx_start_bit: assert property (tx_start |=> !ser_out ##1 (tx_state == TX_SHIFT)) // [R2]
        else $error("frame did not open with a low start bit");
    a_tx_start_event: assert property (tx_start |=> flags.tx_buf_empty && tx_irq) // [R3]
        else $error("start did not set buffer empty and event");
    a_tx_idle_high: assert property ((tx_state == TX_IDLE) |-> ser_out) // [R4]
        else $error("transmit line low while idle");
    a_tx_unarmed_write: assert property (data_wr && !arm_tx && flags.tx_buf_empty
                                         |=> flags.tx_buf_empty) // [R5]
        else $error("unarmed write was accepted");
    a_rx_load_full: assert property (rx_load |=> flags.rx_buf_full && rx_irq
                                     && rx_holding == $past(rx_data)) // [R7]
        else $error("received byte not loaded with full flag");
    a_rx_overrun_keep: assert property (rx_overrun |=> flags.overrun_err
                                        && $stable(rx_holding) && !rx_irq) // [R11]
        else $error("overrun did not keep buffer");
    a_rx_oe_block: assert property (flags.overrun_err && rx_state == RX_IDLE
                                    |=> rx_state == RX_IDLE) // [R12]
        else $error("frame started during overrun");
    a_rx_flag_clear: assert property (data_rd && arm_rx && !rx_load |=> !flags.rx_buf_full
                                      && !flags.parity_err && !flags.framing_err) // [R13]
        else $error("flags not cleared by buffer read");
    a_rx_late_oe: assert property (data_rd && arm_rx && !oe_seen && flags.overrun_err
                                   |=> flags.overrun_err) // [R14]
        else $error("late overrun was cleared");
    a_tx_done_clear: assert property (tx_start |=> !flags.tx_done) // [R16]
        else $error("done flag not cleared at start");

    c_tx_frame: cover property (tx_start ##1 tx_irq);
    c_rx_load: cover property (rx_load);
    c_rx_overrun: cover property (rx_overrun);
    c_rx_framing: cover property (rx_load && (rx_fe_acc || (is_stop && !bitval)));

endmodule // uts_uart
`default_nettype wire

// file: uts_peer.sv
`timescale 1ns/1ps
`default_nettype none
module uts_peer (
    // Clock
    input wire logic clk,
    // Serial lines seen from the remote side
    input wire logic tx_line,
    output logic rx_line
);
    int bitc = 208;

    initial rx_line = 1'b1;

    // Drive a frame LSB first, each bit bitc cycles, then idle high
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_line <= f[i];
            repeat (bitc - 1) @(posedge clk);
        end
        @(posedge clk);
        rx_line <= 1'b1;
    endtask

    // Catch the next frame, sampling each bit at its middle
    task automatic grab(output logic [11:0] f, input int n);
        // Unsent positions read as idle high; returns mid last bit
        f = '1;
        while (tx_line !== 1'b0) @(negedge clk);
        repeat (bitc / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            if (i > 0) repeat (bitc) @(posedge clk);
            f[i] = tx_line;
        end
    endtask
endmodule // uts_peer
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import uts_pkg::*; ();
    typedef struct packed {
        logic [7:0] ctrl;
        logic rxs;
        logic [7:0] d;
        logic [1:0] inj;
        logic [7:0] st;
        logic [15:0] bitc;
    } uts_row_s;

    // Baud codes 0, 6 (timer) and 7; parity off, odd, even; error injection
    uts_row_s rows [5] = '{
        '{8'hc0, 1'b0, 8'ha5, 2'h0, 8'h1c, 16'h00d0},
        '{8'hc8, 1'b0, 8'h3c, 2'h1, 8'h9c, 16'h00d0},
        '{8'hf8, 1'b1, 8'h81, 2'h2, 8'h5c, 16'h00d0},
        '{8'hde, 1'b1, 8'h7f, 2'h2, 8'h5c, 16'h00d0},
        '{8'hc7, 1'b0, 8'h00, 2'h0, 8'h1c, 16'h0600}};
    uts_row_s r;
    logic clk, rst_b, psel, penable, pwrite, ser_in, ser_out, tx_irq, rx_irq, pready, pslverr;
    logic tmr = 1'b0;
    logic psl;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] fr, got, got2;
    int fails, checks, n, tc, ntx, nrx;

    uts_uart uts_uart_i (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ser_in(ser_in), .ser_out(ser_out),
        .timer_five_out(tmr), .tx_irq(tx_irq), .rx_irq(rx_irq));
    uts_peer uts_peer_i (.clk(clk), .tx_line(ser_out), .rx_line(ser_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Timer pulse every 13 cycles, event counters
    always @(posedge clk) begin
        tc <= (tc == 12) ? 0 : tc + 1;
        tmr <= (tc == 12);
        if (tx_irq === 1'b1) ntx <= ntx + 1;
        if (rx_irq === 1'b1) nrx <= nrx + 1;
    end

    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        if (k == 100) fails++;
        rd = prdata;
        psl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic rdst(input logic [7:0] e);
        apb(1'b0, ADDR_STATUS, 8'h00);
        chk(rd, 32'(e));
    endtask

    function automatic logic [11:0] mk(input logic [7:0] d, input logic pa, input logic ev,
        input logic two, output int nb);
        logic [11:0] f;
        f = 12'hfff;
        f[0] = 1'b0;
        f[8:1] = d;
        nb = 9;
        if (pa) begin
            f[9] = ev ? ^d : ~^d;
            nb++;
        end
        nb += two ? 2 : 1;
        return f;
    endfunction

    task automatic feed(input logic [7:0] d);
        fr = mk(d, 1'b0, 1'b0, 1'b0, n);
        uts_peer_i.send(fr, n);
        repeat (40) @(posedge clk);
    endtask

    task automatic summarize;
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        summarize();
    end

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rdst(8'h0c);
        chk(32'(ser_out), 32'h0000_0001);
        apb(1'b0, 16'h0010, 8'h00);
        chk(32'(psl), 32'h0000_0001);
        foreach (rows[i]) begin
            r = rows[i];
            uts_peer_i.bitc = int'(r.bitc);
            apb(1'b1, ADDR_CTRL_ONE, r.ctrl);
            apb(1'b1, ADDR_CTRL_TWO, {7'h00, r.rxs});
            fr = mk(r.d, r.ctrl[3], r.ctrl[4], r.ctrl[5], n);
            fork
                uts_peer_i.grab(got, n);
                begin
                    rdst(8'h0c);
                    apb(1'b1, ADDR_DATA, r.d);
                end
            join
            chk(32'(got), 32'(fr));
            repeat (20) @(posedge clk);
            fr = mk(r.d, r.ctrl[3], r.ctrl[4], r.rxs, n);
            if (r.inj == 2'h1) fr[9] = ~fr[9];
            if (r.inj == 2'h2) fr[n-1] = 1'b0;
            uts_peer_i.send(fr, n);
            repeat (40) @(posedge clk);
            rdst(r.st);
            apb(1'b0, ADDR_DATA, 8'h00);
            chk(rd, 32'(r.d));
            rdst(8'h0c);
        end
        uts_peer_i.bitc = 208;
        apb(1'b1, ADDR_CTRL_ONE, 8'hc0);
        fork
            begin
                uts_peer_i.grab(got, 10);
                uts_peer_i.grab(got2, 10);
            end
            begin
                rdst(8'h0c);
                apb(1'b1, ADDR_DATA, 8'h5a);
                repeat (5) @(posedge clk);
                rdst(8'h04);
                apb(1'b1, ADDR_DATA, 8'h96);
            end
        join
        chk(32'(got), 32'(mk(8'h5a, 1'b0, 1'b0, 1'b0, n)));
        chk(32'(got2), 32'(mk(8'h96, 1'b0, 1'b0, 1'b0, n)));
        // Let the last stop bit finish before looking at the done flag
        repeat (200) @(posedge clk);
        apb(1'b1, ADDR_DATA, 8'h33);
        rdst(8'h0c);
        chk(32'(ser_out), 32'h0000_0001);
        feed(8'h11);
        rdst(8'h1c);
        feed(8'h22);
        apb(1'b0, ADDR_DATA, 8'h00);
        chk(rd, 32'h0000_0011);
        rdst(8'h2c);
        feed(8'h33);
        rdst(8'h2c);
        apb(1'b0, ADDR_DATA, 8'h00);
        chk(rd, 32'h0000_0011);
        rdst(8'h0c);
        // Receive disabled in mid-frame: that frame lands, the next does not
        fork
            feed(8'h44);
            begin
                repeat (600) @(posedge clk);
                apb(1'b1, ADDR_CTRL_ONE, 8'h80);
            end
        join
        rdst(8'h1c);
        apb(1'b0, ADDR_DATA, 8'h00);
        chk(rd, 32'h0000_0044);
        feed(8'h55);
        rdst(8'h0c);
        chk(32'(ntx), 32'h0000_0007);
        chk(32'(nrx), 32'h0000_0007);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
